/* hw/pdt_pkg.sv */
package pdt_pkg;
	// ==========================================
	// register map (byte addresses, one word each)
	localparam logic [7:0] off_primary_dead_time = 8'h00;
	localparam logic [7:0] off_alternate_dead_time = 8'h04;
	localparam logic [7:0] off_trigger_control = 8'h08;
	localparam int addr_bits = 8;
	// ==========================================
	// field layout
	localparam int dead_time_bits = 14;
	localparam int div_bits = 4;
	localparam int div_lsb = 12;
	localparam int combine_pos = 7;
	localparam int strt_bits = 6;
	localparam int strt_lsb = 0;
	// ==========================================
	// reset values
	localparam logic [13:0] dead_time_reset = 14'h0000;
	localparam logic [3:0] div_reset = 4'h0;
	localparam logic combine_reset = 1'b0;
	localparam logic [5:0] strt_reset = 6'h00;
	// ==========================================
	// ahb encodings
	localparam logic [1:0] htrans_nonseq = 2'h2;
	localparam logic hresp_okay = 1'b0;
endpackage

/* hw/pdt_regs.sv */
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
module pdt_regs (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// pwm generator side
	input wire logic module_enable,
	input wire logic pwm_cycle,
	input wire logic trig_primary_event,
	input wire logic trig_secondary_event,
	// dead-time unit and converter triggers
	output logic [13:0] primary_dead_time,
	output logic [13:0] alternate_dead_time,
	output logic trig_out,
	output logic trig_secondary_out
);
	// ==========================================
	// state
	typedef struct packed {
		logic [13:0] prim;
		logic [13:0] alt;
		logic [3:0] div;
		logic combine;
		logic [5:0] strt;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic ready;
		logic en_q;
		logic started;
		logic [5:0] strt_cnt;
		logic [3:0] div_cnt;
		logic tout;
		logic tout2;
	} pdt_state_t;

	pdt_state_t s;
	pdt_state_t next_s;

	// read mux, called only from the comb process; the checks read the fields directly
	function automatic logic [31:0] pdt_read(input pdt_state_t st, input logic [7:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (a)
			pdt_pkg::off_primary_dead_time: d = {18'h00000, st.prim};
			pdt_pkg::off_alternate_dead_time: d = {18'h00000, st.alt};
			pdt_pkg::off_trigger_control: d = {16'h0000, st.div, 4'h0, st.combine, 1'b0, st.strt};
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	logic addr_ok;
	logic [7:0] a_addr;
	logic ev;
	assign addr_ok = hsel && hready && (htrans == pdt_pkg::htrans_nonseq || htrans == 2'h3);
	assign a_addr = haddr[7:0];
	// combined mode folds the secondary event into the primary stream
	assign ev = trig_primary_event || (s.combine && trig_secondary_event);

	// ==========================================
	// next state
	always_comb begin
		next_s = s;
		next_s.ready = 1'b1;
		next_s.tout = 1'b0;
		next_s.tout2 = 1'b0;
		// write data phase; only the implemented fields are taken
		next_s.wr_pend = 1'b0;
		if (s.wr_pend) begin
			unique case (s.wr_addr)
				pdt_pkg::off_primary_dead_time: next_s.prim = hwdata[13:0];
				pdt_pkg::off_alternate_dead_time: next_s.alt = hwdata[13:0];
				pdt_pkg::off_trigger_control: begin
					next_s.div = hwdata[pdt_pkg::div_lsb +: pdt_pkg::div_bits];
					next_s.combine = hwdata[pdt_pkg::combine_pos];
					next_s.strt = hwdata[pdt_pkg::strt_lsb +: pdt_pkg::strt_bits];
				end
				default: next_s.prim = s.prim;
			endcase
		end
		// address phase
		if (addr_ok && hwrite) begin
			next_s.wr_pend = 1'b1;
			next_s.wr_addr = a_addr;
		end
		// read sees a write still in its data phase, so back-to-back access is coherent
		if (addr_ok && !hwrite) begin
			next_s.rdata = pdt_read(next_s, a_addr);
		end else begin
			next_s.rdata = 32'h0000_0000;
		end
		// start delay after enable
		next_s.en_q = module_enable;
		if (!module_enable) begin
			next_s.started = 1'b0;
			next_s.strt_cnt = 6'h00;
			next_s.div_cnt = 4'h0;
		end else if (!s.en_q) begin
			next_s.started = (s.strt == 6'h00);
			next_s.strt_cnt = 6'h00;
			next_s.div_cnt = 4'h0;
		end else if (!s.started && pwm_cycle) begin
			next_s.strt_cnt = s.strt_cnt + 6'h01;
			if (s.strt_cnt + 6'h01 >= s.strt) begin
				next_s.started = 1'b1;
			end
		end
		// postscaler: counting from zero to the code gives every (code+1)th event
		if (s.started && module_enable) begin
			if (ev) begin
				if (s.div_cnt >= s.div) begin
					next_s.div_cnt = 4'h0;
					next_s.tout = 1'b1;
				end else begin
					next_s.div_cnt = s.div_cnt + 4'h1;
				end
			end
			// separate mode sends the secondary event on its own line
			next_s.tout2 = !s.combine && trig_secondary_event;
		end
	end

	// ==========================================
	// registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign hrdata = s.rdata;
	assign hreadyout = s.ready;
	assign hresp = pdt_pkg::hresp_okay;
	assign primary_dead_time = s.prim;
	assign alternate_dead_time = s.alt;
	assign trig_out = s.tout;
	assign trig_secondary_out = s.tout2;

	// ==========================================
	// checks
	wire rd_prim = addr_ok && !hwrite && a_addr == pdt_pkg::off_primary_dead_time && !s.wr_pend;
	wire rd_alt = addr_ok && !hwrite && a_addr == pdt_pkg::off_alternate_dead_time && !s.wr_pend;
	wire rd_trg = addr_ok && !hwrite && a_addr == pdt_pkg::off_trigger_control && !s.wr_pend;

	prim_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s.wr_pend && s.wr_addr == pdt_pkg::off_primary_dead_time |=> primary_dead_time == $past(hwdata[13:0]))
		else $error("primary dead time not written");
	alt_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s.wr_pend && s.wr_addr == pdt_pkg::off_alternate_dead_time |=> alternate_dead_time == $past(hwdata[13:0]))
		else $error("alternate dead time not written");
	dt_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_prim || rd_alt |=> hrdata[31:14] == 18'h00000 && hrdata[13:0] == $past(rd_prim ? s.prim : s.alt))
		else $error("dead time read wrong");
	div_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
		trig_out |-> $past(s.div_cnt) >= $past(s.div) && $past(ev))
		else $error("trigger out without full count");
	div_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s.started && module_enable && ev && s.div == 4'h0 && !s.wr_pend |=> trig_out)
		else $error("code zero must pass every event");
	split_trig_a: assert property (@(posedge hclk) disable iff (!hresetn)
		trig_secondary_out |-> !$past(s.combine) && $past(trig_secondary_event))
		else $error("secondary trigger while combined");
	start_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		trig_out || trig_secondary_out |-> $past(s.started))
		else $error("trigger before start delay");
	start_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		module_enable && !s.en_q && s.strt == 6'h00 |=> s.started)
		else $error("zero start delay not immediate");
	trg_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_trg |=> hrdata[31:16] == 16'h0000 && hrdata[11:8] == 4'h0 && !hrdata[6])
		else $error("unimplemented trigger bits read nonzero");
	trg_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s.wr_pend && s.wr_addr == pdt_pkg::off_trigger_control
		|=> s.div == $past(hwdata[15:12]) && s.strt == $past(hwdata[5:0]))
		else $error("trigger control not written");
	// a write to another offset must leave the dead-time values alone
	prim_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!(s.wr_pend && s.wr_addr == pdt_pkg::off_primary_dead_time) |=> $stable(primary_dead_time))
		else $error("primary dead time moved without a write");
	alt_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!(s.wr_pend && s.wr_addr == pdt_pkg::off_alternate_dead_time) |=> $stable(alternate_dead_time))
		else $error("alternate dead time moved without a write");
	combine_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s.combine |=> !trig_secondary_out)
		else $error("secondary line active while combined");
	combine_merge_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s.started && module_enable && s.combine && s.div == 4'h0 && trig_secondary_event |=> trig_out)
		else $error("secondary event not merged");
	start_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
		module_enable && s.en_q && !s.started && !pwm_cycle |=> !s.started)
		else $error("start delay ended without a pwm cycle");
	enable_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!module_enable |=> !s.started && !trig_out && !trig_secondary_out)
		else $error("trigger while disabled");

	div_wrap_c: cover property (@(posedge hclk) disable iff (!hresetn) trig_out && s.div == 4'hd);
	delay_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(s.started) && s.strt == 6'h3f);
	sep_c: cover property (@(posedge hclk) disable iff (!hresetn) trig_out && trig_secondary_out);
	merge_c: cover property (@(posedge hclk) disable iff (!hresetn)
		s.started && s.combine && trig_primary_event && trig_secondary_event);
	unmapped_c: cover property (@(posedge hclk) disable iff (!hresetn) addr_ok && !hwrite && a_addr == 8'h0c);
endmodule

/* bench/pdt_trig_sink.sv */
`timescale 1ns/1ns
module pdt_trig_sink (
	// clock, reset and count clear
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clr,
	// converter trigger inputs
	input wire logic trig_out,
	input wire logic trig_secondary_out,
	output logic [7:0] n_pri,
	output logic [7:0] n_sec
);
	// the converter only sees pulses, so it just tallies them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{n_pri, n_sec} <= 16'h0000;
		end else begin
			n_pri <= clr ? 8'h00 : n_pri + 8'(trig_out);
			n_sec <= clr ? 8'h00 : n_sec + 8'(trig_secondary_out);
		end
	end
endmodule

/* bench/pdt_regs_tb.sv */
`timescale 1ns/1ns
module pdt_regs_tb;
	logic hclk, hresetn, hwrite, rd_dp, en, pwm, ep, es, clr, hreadyout, hresp, to, tso;
	logic [31:0] haddr, hwdata, hrdata, lf;
	logic [1:0] htrans;
	logic [13:0] pdt, adt;
	logic [7:0] np, ns;
	logic [31:0] q[$];
	int bad_count, checks;
	pdt_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .module_enable(en), .pwm_cycle(pwm),
		.trig_primary_event(ep), .trig_secondary_event(es), .primary_dead_time(pdt),
		.alternate_dead_time(adt), .trig_out(to), .trig_secondary_out(tso));
	pdt_trig_sink u_sink (.hclk(hclk), .hresetn(hresetn), .clr(clr), .trig_out(to),
		.trig_secondary_out(tso), .n_pri(np), .n_sec(ns));
	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic test_done;
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= pdt_pkg::htrans_nonseq;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		rd_dp <= !w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_dp <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic burst(input int n, input logic p, input logic s);
		ep <= p;
		es <= s;
		repeat (n) @(posedge hclk);
		{ep, es} <= 2'b00;
		repeat (3) @(posedge hclk);
	endtask
	// enable rises only after the new control word is in, so counters start clean
	task automatic arm(input logic [31:0] ctl);
		en <= 1'b0;
		clr <= 1'b1;
		bus(1'b1, pdt_pkg::off_trigger_control, ctl);
		en <= 1'b1;
		clr <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask
	always @(posedge hclk) begin
		if (rd_dp === 1'b1 && hreadyout === 1'b1) begin
			chk(hrdata, q.pop_front());
			chk({31'h0, hresp}, {31'h0, pdt_pkg::hresp_okay});
		end
	end
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	initial begin
		#100000;
		bad_count++;
		test_done();
	end
	initial begin
		{hresetn, hwrite, rd_dp, en, pwm, ep, es, clr, htrans} = '0;
		{haddr, hwdata} = '0;
		lf = 32'h3cc240b7;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(pdt_pkg::off_primary_dead_time, 32'h0);
		rd(pdt_pkg::off_alternate_dead_time, 32'h0);
		rd(pdt_pkg::off_trigger_control, 32'h0);
		bus(1'b1, pdt_pkg::off_primary_dead_time, 32'hffffffff);
		rd(pdt_pkg::off_primary_dead_time, 32'h3fff);
		chk({18'h0, pdt}, 32'h3fff);
		lf = nxt(lf);
		bus(1'b1, pdt_pkg::off_alternate_dead_time, lf);
		rd(pdt_pkg::off_alternate_dead_time, lf & 32'h3fff);
		chk({18'h0, adt}, lf & 32'h3fff);
		bus(1'b1, pdt_pkg::off_trigger_control, 32'hffffffff);
		rd(pdt_pkg::off_trigger_control, 32'hf0bf);
		rd(8'h0c, 32'h0);
		for (int c = 0; c < 16; c++) begin
			arm({16'h0, 4'(c), 12'h0});
			burst(3 * c + 2, 1'b1, 1'b0);
			chk({24'h0, np}, 32'h2);
		end
		arm(32'h0080);
		burst(3, 1'b0, 1'b1);
		burst(2, 1'b1, 1'b1);
		chk({16'h0, np, ns}, 32'h0500);
		arm(32'h0000);
		burst(3, 1'b0, 1'b1);
		burst(2, 1'b1, 1'b1);
		chk({16'h0, np, ns}, 32'h0205);
		arm(32'h0002);
		burst(4, 1'b1, 1'b0);
		for (int i = 0; i < 2; i++) begin
			pwm <= 1'b1;
			@(posedge hclk);
			pwm <= 1'b0;
			repeat (2) @(posedge hclk);
			burst(3, 1'b1, 1'b0);
			chk({24'h0, np}, 32'(3 * i));
		end
		// longest start delay: one pwm cycle short of it must still refuse events
		arm(32'h003f);
		for (int i = 0; i < 63; i++) begin
			pwm <= 1'b1;
			@(posedge hclk);
			pwm <= 1'b0;
			@(posedge hclk);
			if (i == 61) begin
				burst(2, 1'b1, 1'b0);
				chk({24'h0, np}, 32'h0);
			end
		end
		burst(2, 1'b1, 1'b0);
		chk({24'h0, np}, 32'h2);
		test_done();
	end
endmodule
